// [src/hlc_pkg.sv]
// Constants, field layout and types of the link channel configuration block.
// Assumes a 32-bit APB master; each 8-bit register sits in the low byte.
package hlc_pkg;
  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam int REG_COUNT = 13;
  localparam logic [7:0] IDX_RX1_STAT = 8'h95;
  localparam int CFG_TX_EN = 0;
  localparam int CFG_TX2_ASN = 1;
  localparam int CFG_TX3_ASN = 2;
  localparam int CFG_TX2_MSK = 3;
  localparam int CFG_TX3_MSK = 4;
  localparam int CFG_RX_EN = 5;
  localparam int CFG_RX2_ASN = 6;
  localparam int CFG_RX3_ASN = 7;
  localparam int CFG_RX2_MSK = 8;
  localparam int CFG_RX3_MSK = 9;
  localparam int CFG_RX1_CTL = 10;
  localparam logic [7:0] REG_IDX [REG_COUNT] = '{8'h84, 8'h86, 8'h87,
    8'h89, 8'h8A, 8'h8B, 8'h8D, 8'h8E, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94};
  localparam logic [7:0] REG_WMASK [REG_COUNT] = '{8'h07, 8'h7F, 8'h7F,
    8'hFF, 8'hFF, 8'h07, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F};
  localparam logic [7:0] REG_RST = 8'h00;
  // Slot units: transmit 2, transmit 3, receive 2, receive 3
  localparam int SLOT_ASN [4] = '{CFG_TX2_ASN, CFG_TX3_ASN, CFG_RX2_ASN,
    CFG_RX3_ASN};
  localparam int SLOT_MSK [4] = '{CFG_TX2_MSK, CFG_TX3_MSK, CFG_RX2_MSK,
    CFG_RX3_MSK};
  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int ASN_EVEN_BIT = 6;
  localparam int ASN_ODD_BIT = 5;
  localparam int CHAN_MSB = 4;
  localparam logic [2:0] MASK_TOP = 3'h7;
  localparam int CTL_LSSU_FIL = 5;
  localparam int CTL_FISU_FIL = 4;
  localparam int CTL_ADRM_LSB = 2;
  localparam int CTL_PROTO = 1;
  localparam int CTL_RECEIVER_RESET = 0;
  localparam int STAT_EMP = 5;
  localparam int STAT_OVH = 4;
  // ---------------------------------------------------------------------
  // Address compare values and defaults
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_CR_MASK = 8'hFD;
  localparam logic [7:0] ADDR_GROUP_A = 8'hFC;
  localparam logic [7:0] ADDR_GROUP_B = 8'hFE;
  localparam int FIFO_DEPTH_DEF = 128;
  localparam int UNIT_W_DEF = 16;
  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    HLC_ADRM_NONE,
    HLC_ADRM_HIGH,
    HLC_ADRM_LOW,
    HLC_ADRM_BOTH
  } hlc_adrm_type;
  typedef enum logic [1:0] {
    HLC_SU_OTHER,
    HLC_SU_FISU,
    HLC_SU_LSSU
  } hlc_su_kind_type;
endpackage

// [src/hlc_pos_if.sv]
// Line position carrier shared by the top and the slot matchers.
// Assumes all fields change on pclk and strobe marks one line bit.
`timescale 1ns/100ps
`default_nettype none
interface hlc_pos_if;
  logic strobe;
  logic frame_odd;
  logic [4:0] channel;
  logic [2:0] bit_idx;
  modport src (output strobe, frame_odd, channel, bit_idx);
  modport sink (input strobe, frame_odd, channel, bit_idx);
endinterface
`default_nettype wire

// [src/hlc_chan_slot.sv]
// Channel, frame parity and bit position matcher for one link unit.
// Assumes a position carrier driven from the pclk domain.
`timescale 1ns/100ps
`default_nettype none
module hlc_chan_slot (
  // Configuration
  input wire logic [7:0] assign_cfg,
  input wire logic [7:0] mask_cfg,
  input wire logic unit_on,
  // Line position
  hlc_pos_if.sink pos,
  // Result
  output logic hit
);
  import hlc_pkg::*;

  // -----------------------------------------------------------------------
  // Match terms
  // -----------------------------------------------------------------------
  wire logic parity_ok = pos.frame_odd ? assign_cfg[ASN_ODD_BIT]
                                       : assign_cfg[ASN_EVEN_BIT];
  // Both selects low leaves channel and mask without effect
  wire logic any_parity = assign_cfg[ASN_ODD_BIT]
                          | assign_cfg[ASN_EVEN_BIT];
  // Codes above 23 never meet a real channel, so they simply never hit
  wire logic chan_ok = pos.channel == assign_cfg[CHAN_MSB:0];
  wire logic [2:0] mask_pos = MASK_TOP - pos.bit_idx;
  wire logic bit_ok = mask_cfg[mask_pos];

  assign hit = pos.strobe & unit_on & any_parity & parity_ok & chan_ok
               & bit_ok;
endmodule
`default_nettype wire

// [src/hlc_top.sv]
// Link channel configuration block: APB register file, slot insertion and
// extraction for units two and three, receiver one unit filter and FIFO.
// Assumes all inputs are produced by logic on pclk.
`timescale 1ns/100ps
`default_nettype none
module hlc_top #(
  parameter int ADDR_W = 12,
  parameter int FIFO_DEPTH = hlc_pkg::FIFO_DEPTH_DEF,
  parameter int UNIT_W = hlc_pkg::UNIT_W_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line position and framing
  input wire logic line_strobe,
  input wire logic line_frame_odd,
  input wire logic [4:0] line_channel,
  input wire logic [2:0] line_bit_idx,
  input wire logic fmt_esf_dm,
  // Transmit stream
  input wire logic tx_line_in,
  input wire logic [1:0] tx_link_data,
  output logic tx_line_out,
  output logic [1:0] tx_link_take,
  output logic tx1_active,
  // Receive stream
  input wire logic rx_line_in,
  output logic rx_link_bit,
  output logic [1:0] rx_link_valid,
  output logic rx1_active,
  output logic [2:0] rx_reset_pulse,
  // Receiver one signalling units
  input wire logic rx1_unit_done,
  input wire hlc_pkg::hlc_su_kind_type rx1_unit_kind,
  input wire logic [UNIT_W-1:0] rx1_unit_word,
  input wire logic [7:0] rx1_addr_hi,
  input wire logic [7:0] rx1_addr_lo,
  input wire logic [7:0] high_address_value,
  input wire logic [7:0] rx1_low_addr_value,
  output logic rx1_unit_accept,
  output logic rx1_unit_discard,
  // Receiver one FIFO
  input wire logic rx1_fifo_wr,
  input wire logic [7:0] rx1_fifo_byte,
  input wire logic rx1_fifo_ovh,
  input wire logic rx1_fifo_rd,
  output logic [7:0] rx1_fifo_rdata,
  output logic rx1_overwrite
);
  import hlc_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);

  // -----------------------------------------------------------------------
  // Parameter checks
  // -----------------------------------------------------------------------
  if (ADDR_W < 10)
    $error("hlc_top: ADDR_W must be at least 10");
  if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH)
    $error("hlc_top: FIFO_DEPTH must be a power of two");
  if (UNIT_W < 1)
    $error("hlc_top: UNIT_W must be positive");

  // -----------------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------------
  logic [7:0] cfg_q [REG_COUNT];
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [REG_COUNT-1:0] reg_hit;
  logic [7:0] rd_byte;
  logic empty_q;
  logic ovh_q;

  wire logic word_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  wire logic [7:0] reg_idx = paddr[9:2];
  wire logic stat_hit = word_ok && (reg_idx == IDX_RX1_STAT);
  wire logic mapped = (|reg_hit) || stat_hit;
  wire logic apb_access = psel & penable;
  // Answer one cycle into the access phase; the write lands at that edge
  wire logic apb_commit = apb_access & pready_q;
  wire logic apb_wr = apb_commit & pwrite;
  wire logic [7:0] stat_byte = (8'(empty_q) << STAT_EMP)
                               | (8'(ovh_q) << STAT_OVH);

  for (genvar k = 0; k < REG_COUNT; k++)
  begin : g_reg
    assign reg_hit[k] = word_ok && (reg_idx == REG_IDX[k]);
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cfg_q[k] <= REG_RST;
      else if (apb_wr && reg_hit[k])
        cfg_q[k] <= pwdata[7:0] & REG_WMASK[k];
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    for (int k = 0; k < REG_COUNT; k++)
      if (reg_hit[k])
        rd_byte = rd_byte | cfg_q[k];
    if (stat_hit)
      rd_byte = rd_byte | stat_byte;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= apb_access & ~pready_q;
      pslverr_q <= apb_access & ~pready_q & ~mapped;
      if (apb_access && !pready_q)
        prdata_q <= pwrite ? 32'h0 : {24'h0, rd_byte};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // -----------------------------------------------------------------------
  // Enables and receiver resets
  // -----------------------------------------------------------------------
  logic [2:0] receiver_reset_prev_q;
  logic [2:0] rx_rst_q;
  logic tx1_on_q;
  logic rx1_on_q;
  wire logic [2:0] tx_en = cfg_q[CFG_TX_EN][2:0];
  wire logic [2:0] rx_en = cfg_q[CFG_RX_EN][2:0];
  wire logic [2:0] receiver_reset_now = {cfg_q[CFG_RX1_CTL+2][CTL_RECEIVER_RESET],
                               cfg_q[CFG_RX1_CTL+1][CTL_RECEIVER_RESET],
                               cfg_q[CFG_RX1_CTL][CTL_RECEIVER_RESET]};
  // Only the rising edge acts; holding the bit high does nothing more
  wire logic [2:0] rst_edge = receiver_reset_now & ~receiver_reset_prev_q;
  wire logic rx1_on = rx_en[0] & fmt_esf_dm;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receiver_reset_prev_q <= 3'h0;
      rx_rst_q <= 3'h0;
      tx1_on_q <= 1'b0;
      rx1_on_q <= 1'b0;
    end
    else
    begin
      receiver_reset_prev_q <= receiver_reset_now;
      rx_rst_q <= rst_edge;
      tx1_on_q <= tx_en[0] & fmt_esf_dm;
      rx1_on_q <= rx1_on;
    end
  end

  assign tx1_active = tx1_on_q;
  assign rx1_active = rx1_on_q;
  assign rx_reset_pulse = rx_rst_q;

  // -----------------------------------------------------------------------
  // Slot insertion and extraction
  // -----------------------------------------------------------------------
  hlc_pos_if pos ();
  logic [3:0] slot_hit;
  logic tx_line_q;
  logic [1:0] tx_take_q;
  logic rx_bit_q;
  logic [1:0] rx_valid_q;
  wire logic [3:0] slot_en = {rx_en[2], rx_en[1], tx_en[2], tx_en[1]};

  assign pos.strobe = line_strobe;
  assign pos.frame_odd = line_frame_odd;
  assign pos.channel = line_channel;
  assign pos.bit_idx = line_bit_idx;

  for (genvar u = 0; u < 4; u++)
  begin : g_slot
    hlc_chan_slot u_slot (
      .assign_cfg(cfg_q[SLOT_ASN[u]]),
      .mask_cfg(cfg_q[SLOT_MSK[u]]),
      .unit_on(slot_en[u]),
      .pos(pos.sink),
      .hit(slot_hit[u])
    );
  end

  // Unit two wins if both units are pointed at the same bit
  wire logic tx_line_d = slot_hit[0] ? tx_link_data[0]
                       : slot_hit[1] ? tx_link_data[1] : tx_line_in;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_line_q <= 1'b0;
      tx_take_q <= 2'h0;
      rx_bit_q <= 1'b0;
      rx_valid_q <= 2'h0;
    end
    else
    begin
      tx_take_q <= {slot_hit[1] & ~slot_hit[0], slot_hit[0]};
      rx_valid_q <= slot_hit[3:2];
      if (line_strobe)
      begin
        tx_line_q <= tx_line_d;
        rx_bit_q <= rx_line_in;
      end
    end
  end

  assign tx_line_out = tx_line_q;
  assign tx_link_take = tx_take_q;
  assign rx_link_bit = rx_bit_q;
  assign rx_link_valid = rx_valid_q;

  // -----------------------------------------------------------------------
  // Receiver one unit filter
  // -----------------------------------------------------------------------
  logic [UNIT_W-1:0] lssu_prev_q;
  logic [UNIT_W-1:0] fisu_prev_q;
  logic lssu_seen_q;
  logic fisu_seen_q;
  logic accept_q;
  logic discard_q;
  wire logic [7:0] ctl1 = cfg_q[CFG_RX1_CTL];
  wire logic ss7 = ctl1[CTL_PROTO];
  wire hlc_adrm_type adrm = hlc_adrm_type'(ctl1[CTL_ADRM_LSB+1:CTL_ADRM_LSB]);
  wire logic [7:0] hi_in = rx1_addr_hi & ADDR_CR_MASK;
  wire logic hi_ok = (hi_in == (high_address_value & ADDR_CR_MASK))
                     || (hi_in == (ADDR_GROUP_A & ADDR_CR_MASK))
                     || (hi_in == (ADDR_GROUP_B & ADDR_CR_MASK));
  wire logic lo_ok = rx1_addr_lo == rx1_low_addr_value;
  wire logic addr_ok = (adrm == HLC_ADRM_NONE) ? 1'b1
                     : (adrm == HLC_ADRM_HIGH) ? hi_ok
                     : (adrm == HLC_ADRM_LOW) ? lo_ok
                     : (hi_ok & lo_ok);
  wire logic is_lssu = rx1_unit_kind == HLC_SU_LSSU;
  wire logic is_fisu = rx1_unit_kind == HLC_SU_FISU;
  wire logic lssu_rep = is_lssu && ctl1[CTL_LSSU_FIL] && lssu_seen_q
                        && (rx1_unit_word == lssu_prev_q);
  wire logic fisu_rep = is_fisu && ctl1[CTL_FISU_FIL] && fisu_seen_q
                        && (rx1_unit_word == fisu_prev_q);
  wire logic keep = ss7 ? ~(lssu_rep | fisu_rep) : addr_ok;
  wire logic unit_in = rx1_unit_done & rx1_on;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lssu_prev_q <= '0;
      fisu_prev_q <= '0;
      lssu_seen_q <= 1'b0;
      fisu_seen_q <= 1'b0;
      accept_q <= 1'b0;
      discard_q <= 1'b0;
    end
    else
    begin
      accept_q <= unit_in & keep;
      discard_q <= unit_in & ~keep;
      if (rst_edge[0])
      begin
        lssu_seen_q <= 1'b0;
        fisu_seen_q <= 1'b0;
      end
      else if (unit_in && ss7)
      begin
        if (is_lssu)
        begin
          lssu_prev_q <= rx1_unit_word;
          lssu_seen_q <= 1'b1;
        end
        if (is_fisu)
        begin
          fisu_prev_q <= rx1_unit_word;
          fisu_seen_q <= 1'b1;
        end
      end
    end
  end

  assign rx1_unit_accept = accept_q;
  assign rx1_unit_discard = discard_q;

  // -----------------------------------------------------------------------
  // Receiver one FIFO
  // -----------------------------------------------------------------------
  logic [8:0] mem_q [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic [7:0] rdata_q;
  logic ovw_q;
  wire logic full = count_q == (PW+1)'(FIFO_DEPTH);
  wire logic fifo_push = rx1_fifo_wr & rx1_on & ~full;
  // A full FIFO keeps its contents; the late byte is lost and flagged
  wire logic fifo_ovw = rx1_fifo_wr & rx1_on & full;
  wire logic fifo_pop = rx1_fifo_rd & (count_q != '0);
  wire logic [8:0] head = mem_q[rd_ptr_q];

  always_ff @(posedge pclk)
  begin
    if (fifo_push)
      mem_q[wr_ptr_q] <= {rx1_fifo_ovh, rx1_fifo_byte};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      rdata_q <= 8'h00;
      ovw_q <= 1'b0;
      empty_q <= 1'b1;
      ovh_q <= 1'b0;
    end
    else if (rst_edge[0])
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ovw_q <= 1'b0;
      empty_q <= 1'b0;
      ovh_q <= 1'b0;
    end
    else
    begin
      ovw_q <= fifo_ovw;
      if (fifo_push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (fifo_pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        rdata_q <= head[7:0];
        ovh_q <= head[8];
      end
      count_q <= count_q + (PW+1)'(fifo_push) - (PW+1)'(fifo_pop);
      if (fifo_push)
        empty_q <= 1'b0;
      else if (fifo_pop && count_q == (PW+1)'(1))
        empty_q <= 1'b1;
    end
  end

  assign rx1_fifo_rdata = rdata_q;
  assign rx1_overwrite = ovw_q;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire logic tx2_mask_sel = cfg_q[CFG_TX2_MSK][MASK_TOP - line_bit_idx];
  wire logic tx2_chan_sel = line_channel == cfg_q[CFG_TX2_ASN][CHAN_MSB:0];
  wire logic rx2_mask_sel = cfg_q[CFG_RX2_MSK][MASK_TOP - line_bit_idx];
  wire logic tx2_odd_off = line_frame_odd & ~cfg_q[CFG_TX2_ASN][ASN_ODD_BIT];
  wire logic head_ovh = head[8];

  a_tx_pass_through: assert property (
    line_strobe && !slot_hit[0] && !slot_hit[1]
    |=> tx_line_out == $past(tx_line_in))
    else $error("unselected line bit was modified");
  a_tx_disabled: assert property (
    !tx_en[1] |=> !tx_link_take[0])
    else $error("disabled transmitter took data");
  a_tx1_fmt_gate: assert property (
    tx_en[0] && !fmt_esf_dm |=> !tx1_active)
    else $error("transmitter one active outside ESF/DM");
  a_tx_parity_gate: assert property (
    tx2_odd_off |=> !tx_link_take[0])
    else $error("insertion into unselected frame parity");
  a_tx_slot_match: assert property (
    tx_link_take[0] |-> $past(tx2_mask_sel) && $past(tx2_chan_sel))
    else $error("insertion outside masked channel bit");
  a_tx_insert_data: assert property (
    tx_link_take[0] |-> tx_line_out == $past(tx_link_data[0]))
    else $error("inserted bit is not link data");
  a_rx_disabled: assert property (
    !rx_en[1] |=> !rx_link_valid[0])
    else $error("disabled receiver extracted data");
  a_rx_mask_gate: assert property (
    rx_link_valid[0] |-> $past(rx2_mask_sel))
    else $error("extraction outside masked bit");
  a_rx1_fmt_gate: assert property (
    rx1_unit_done && !fmt_esf_dm |=> !rx1_unit_accept && !rx1_unit_discard)
    else $error("receiver one acted outside ESF/DM");
  a_lssu_repeat: assert property (
    unit_in && ss7 && lssu_rep |=> rx1_unit_discard && !rx1_unit_accept)
    else $error("repeated status unit not dropped");
  a_fisu_nofilter: assert property (
    unit_in && ss7 && is_fisu && !ctl1[CTL_FISU_FIL] |=> rx1_unit_accept)
    else $error("fill unit dropped with filter off");
  a_addr_none: assert property (
    unit_in && !ss7 && adrm == HLC_ADRM_NONE |=> rx1_unit_accept)
    else $error("unit dropped with no address compare");
  a_addr_group: assert property (
    unit_in && !ss7 && adrm == HLC_ADRM_HIGH
    && (rx1_addr_hi | 8'h02) == ADDR_GROUP_B |=> rx1_unit_accept)
    else $error("group high address not matched");
  a_receiver_reset_flush: assert property (
    rst_edge[0] |=> rx_reset_pulse[0] && !empty_q && !ovh_q && count_q == '0
    ##1 !rx_reset_pulse[0])
    else $error("receiver reset did not flush");
  a_empty_last: assert property (
    fifo_pop && !fifo_push && count_q == (PW+1)'(1) && !rst_edge[0]
    |=> empty_q)
    else $error("empty flag not set after last read");
  a_ovh_flag: assert property (
    fifo_pop && !rst_edge[0] |=> ovh_q == $past(head_ovh))
    else $error("overhead flag does not follow byte");
  a_overwrite: assert property (
    fifo_ovw && !fifo_pop && !rst_edge[0]
    |=> rx1_overwrite && count_q == $past(count_q))
    else $error("full FIFO write not flagged");

  c_tx_insert: cover property (tx_link_take[0] ##1 tx_link_take[0]);
  c_rx_extract: cover property (rx_link_valid[1]);
  c_fifo_full: cover property (rx1_overwrite);
  c_lssu_drop: cover property (unit_in && lssu_rep ##1 rx1_unit_discard);
endmodule
`default_nettype wire

// [dv/hlc_line_model.sv]
// Line side model: frame position source and line bit pattern.
// Assumes one bit strobe per pclk; 24 channels of 8 bits per frame.
`timescale 1ns/100ps
`default_nettype none
module hlc_line_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line position and bit
  output logic strobe,
  output logic frame_odd,
  output logic [4:0] channel,
  output logic [2:0] bit_idx,
  output logic line_bit
);
  logic [7:0] pos_q;
  logic wrap;
  assign wrap = pos_q == 8'hBF;
  assign channel = pos_q[7:3];
  assign bit_idx = pos_q[2:0];
  // Changes every bit except the first of each channel 0 to 23, so a stale sample shows
  assign line_bit = pos_q[3] ^ pos_q[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe <= 1'b0;
      frame_odd <= 1'b0;
      pos_q <= 8'h00;
    end
    else
    begin
      strobe <= 1'b1;
      pos_q <= strobe ? (wrap ? 8'h00 : pos_q + 8'h01) : pos_q;
      frame_odd <= frame_odd ^ (strobe & wrap);
    end
  end
endmodule
`default_nettype wire

// [dv/hlc_link_channel_config_tb.sv]
// Bench: registers, slot counts, unit filter, FIFO flags, receiver reset.
// Assumes the line model strobes every cycle after reset.
`timescale 1ns/100ps
`default_nettype none
`define CHK(s, x, g) begin checks++; if ((g) !== (x)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", s, x, g); end end
module hlc_link_channel_config_tb;
  import hlc_pkg::*;
  typedef struct {logic [7:0] en, slot, mask, pos; int cnt;} hlc_row_type;
  hlc_row_type rows [6] = '{
    '{8'h02, 8'h45, 8'h80, 8'h28, 1},
    '{8'h02, 8'h25, 8'h01, 8'h2F, 1},
    '{8'h02, 8'h65, 8'hFF, 8'h00, 16},
    '{8'h02, 8'h05, 8'hFF, 8'h00, 0},
    '{8'h00, 8'h65, 8'hFF, 8'h00, 0},
    '{8'h02, 8'h77, 8'h01, 8'hBF, 2}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic fmt = 0, udone = 0, fwr = 0, fovh = 0, frd = 0;
  logic pready, pslverr, e, strobe, odd, lbit, txo, rxb, t1, r1, acc, dis;
  logic ovw;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [4:0] chan;
  logic [2:0] bidx, rp;
  logic [1:0] take, valid;
  logic [7:0] fbyte = '0, fdata, pos_prev, pos_take;
  logic [15:0] uword = '0;
  logic [7:0] ahi = '0;
  hlc_su_kind_type ukind = HLC_SU_OTHER;
  int n_errors = 0, checks = 0, n_take, n_valid, cyc = 0, i, n;
  int n_take3, n_valid3;
  hlc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_strobe(strobe), .line_frame_odd(odd),
    .line_channel(chan), .line_bit_idx(bidx), .fmt_esf_dm(fmt),
    .tx_line_in(lbit), .tx_link_data(2'b10), .tx_line_out(txo),
    .tx_link_take(take), .tx1_active(t1), .rx_line_in(lbit),
    .rx_link_bit(rxb), .rx_link_valid(valid), .rx1_active(r1),
    .rx_reset_pulse(rp), .rx1_unit_done(udone), .rx1_unit_kind(ukind),
    .rx1_unit_word(uword), .rx1_addr_hi(ahi), .rx1_addr_lo(ahi),
    .high_address_value(8'h27), .rx1_low_addr_value(8'h25),
    .rx1_unit_accept(acc), .rx1_unit_discard(dis), .rx1_fifo_wr(fwr),
    .rx1_fifo_byte(fbyte), .rx1_fifo_ovh(fovh), .rx1_fifo_rd(frd),
    .rx1_fifo_rdata(fdata), .rx1_overwrite(ovw));
  hlc_line_model line (.pclk, .presetn, .strobe, .frame_odd(odd),
    .channel(chan), .bit_idx(bidx), .line_bit(lbit));
  always #2.5 pclk = ~pclk;
  task finish_test;
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Position of the strobe that caused each pulse, one cycle back
  always @(posedge pclk)
  begin
    cyc++;
    pos_prev <= {chan, bidx};
    if (take[0] === 1'b1)
    begin
      n_take++;
      pos_take <= pos_prev;
      `CHK("txo", 1'b0, txo)
    end
    else if (take[1] === 1'b1)
    begin
      n_take3++;
      `CHK("txo3", 1'b1, txo)
    end
    // Skip the first cycles, before the bench has a line position
    else if (cyc > 8)
      `CHK("txo", pos_prev[3] ^ pos_prev[0], txo)
    if (valid[0] === 1'b1)
    begin
      n_valid++;
      `CHK("rxb", pos_prev[3] ^ pos_prev[0], rxb)
    end
    if (valid[1] === 1'b1)
    begin
      n_valid3++;
      `CHK("rxb3", pos_prev[3] ^ pos_prev[0], rxb)
    end
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test;
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    `CHK("prdata", {24'h0, x}, r)
  endtask
  task unit(input hlc_su_kind_type k, input logic [1:0] x);
    @(posedge pclk);
    udone <= 1'b1;
    ukind <= k;
    uword <= 16'h1234;
    @(posedge pclk);
    udone <= 1'b0;
    @(posedge pclk);
    `CHK("unit", x, {acc, dis})
  endtask
  task fifo(input logic w, input logic [7:0] b, input logic o);
    @(posedge pclk);
    fwr <= w;
    frd <= ~w;
    fbyte <= b;
    fovh <= o;
    @(posedge pclk);
    fwr <= 1'b0;
    frd <= 1'b0;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h254, 8'h20);
    apb(1'b1, 12'h254, 8'hFF);
    rd(12'h254, 8'h20);
    apb(1'b0, 12'h300, 8'h00);
    `CHK("pslverr", 1'b1, e)
    for (i = 0; i < REG_COUNT; i++)
    begin
      rd({2'b00, REG_IDX[i], 2'b00}, REG_RST);
      apb(1'b1, {2'b00, REG_IDX[i], 2'b00}, 8'hFF);
      rd({2'b00, REG_IDX[i], 2'b00}, REG_WMASK[i]);
      apb(1'b1, {2'b00, REG_IDX[i], 2'b00}, 8'h00);
    end
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'h210, rows[i].en);
      apb(1'b1, 12'h218, rows[i].slot);
      apb(1'b1, 12'h224, rows[i].mask);
      apb(1'b1, 12'h22C, rows[i].en);
      apb(1'b1, 12'h234, rows[i].slot);
      apb(1'b1, 12'h240, rows[i].mask);
      repeat (4) @(negedge pclk);
      n_take = 0;
      n_valid = 0;
      repeat (384) @(negedge pclk);
      `CHK("takes", rows[i].cnt, n_take)
      `CHK("valids", rows[i].cnt, n_valid)
      if (rows[i].pos != 8'h00)
        `CHK("pos", rows[i].pos, pos_take)
    end
    // Units three alone; their link data is 1, so a take shows whose bit
    apb(1'b1, 12'h210, 8'h04);
    apb(1'b1, 12'h21C, 8'h65);
    apb(1'b1, 12'h228, 8'h81);
    apb(1'b1, 12'h22C, 8'h04);
    apb(1'b1, 12'h238, 8'h65);
    apb(1'b1, 12'h244, 8'h81);
    repeat (4) @(negedge pclk);
    n_take3 = 0;
    n_valid3 = 0;
    repeat (384) @(negedge pclk);
    `CHK("takes3", 4, n_take3)
    `CHK("valids3", 4, n_valid3)
    apb(1'b1, 12'h22C, 8'h01);
    fmt <= 1'b1;
    apb(1'b1, 12'h210, 8'h01);
    // Enable lands at the commit edge, the active flag one edge later
    repeat (2) @(posedge pclk);
    `CHK("t1", 1'b1, t1)
    `CHK("r1", 1'b1, r1)
    apb(1'b1, 12'h248, 8'h32);
    unit(HLC_SU_LSSU, 2'b10);
    unit(HLC_SU_LSSU, 2'b01);
    unit(HLC_SU_FISU, 2'b10);
    unit(HLC_SU_FISU, 2'b01);
    apb(1'b1, 12'h248, 8'h02);
    unit(HLC_SU_FISU, 2'b10);
    apb(1'b1, 12'h248, 8'h30);
    unit(HLC_SU_LSSU, 2'b10);
    // Address modes; programmed high value 27h, low value 25h
    ahi <= 8'h25;
    apb(1'b1, 12'h248, 8'h04);
    unit(HLC_SU_OTHER, 2'b10);
    ahi <= 8'hFE;
    unit(HLC_SU_OTHER, 2'b10);
    ahi <= 8'h26;
    unit(HLC_SU_OTHER, 2'b01);
    apb(1'b1, 12'h248, 8'h08);
    unit(HLC_SU_OTHER, 2'b01);
    ahi <= 8'h25;
    apb(1'b1, 12'h248, 8'h0C);
    unit(HLC_SU_OTHER, 2'b10);
    fifo(1'b1, 8'hA5, 1'b1);
    fifo(1'b1, 8'h3C, 1'b0);
    rd(12'h254, 8'h00);
    fifo(1'b0, 8'h00, 1'b0);
    rd(12'h254, 8'h10);
    `CHK("fdata", 8'hA5, fdata)
    fifo(1'b0, 8'h00, 1'b0);
    rd(12'h254, 8'h20);
    for (i = 0; i < 128; i++)
      fifo(1'b1, i[7:0], 1'b0);
    @(posedge pclk);
    `CHK("ovw", 1'b0, ovw)
    fifo(1'b1, 8'h77, 1'b0);
    @(posedge pclk);
    `CHK("ovw", 1'b1, ovw)
    apb(1'b1, 12'h248, 8'h01);
    for (n = 0; n < 8 && rp[0] !== 1'b1; n++)
      @(posedge pclk);
    `CHK("rp", 3'b001, rp)
    rd(12'h254, 8'h00);
    fifo(1'b1, 8'h11, 1'b0);
    fifo(1'b0, 8'h00, 1'b0);
    rd(12'h254, 8'h20);
    `CHK("fdata", 8'h11, fdata)
    fmt <= 1'b0;
    unit(HLC_SU_FISU, 2'b00);
    `CHK("t1", 1'b0, t1)
    finish_test;
  end
endmodule
`default_nettype wire
